/* verilog/fsp_pkg.sv */
// What this block does
// - Four-bit rate code picks frame repetition from 166.67 Hz up to 64 kHz, or 1 Hz.
// - Style clear gives a 50% clock, except 1 Hz which stays high 4 ms.
// - Style set gives a frame pulse aligned to the synthesized E1-family clock.
// - Edge bit aligns the pulse to rising or falling sync edge; ignored at 1 Hz.
// - Width codes 000 to 100 give one period of 4.096 to 65.536 MHz.
// - Width 111 lasts one synthesized clock cycle; 101 and 110 are reserved and idle the generator.
// - A 22-bit phase offset is assembled from byte registers, low and mid bytes first.
// - Low offset bits delay the pulse in 262.144 MHz periods.
// - Offset bits 21:16 add delay in whole 8 kHz cycles.
package fsp_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_RATE = 8'h3E;
    localparam logic [7:0] ADDR_SHAPE = 8'h3F;
    localparam logic [7:0] ADDR_OFS_LOW = 8'h40;
    localparam logic [7:0] ADDR_OFS_MID = 8'h41;
    localparam logic [7:0] ADDR_OFS_HIGH = 8'h42;
    localparam logic [7:0] ADDR_STATUS = 8'h43;

    localparam logic [7:0] RATE_RST = 8'h05;
    localparam logic [7:0] SHAPE_RST = 8'h83;
    localparam logic [7:0] OFS_RST = 8'h00;

    // ----------------------------------------
    // Field layout
    // ----------------------------------------
    localparam int SHAPE_STYLE_BIT = 0;
    localparam int SHAPE_EDGE_BIT = 1;
    localparam int SHAPE_WIDTH_LSB = 4;
    localparam int SHAPE_POL_BIT = 7;
    localparam int OFS_HIGH_BITS = 6;
    localparam int OFS_BITS = 22;
    localparam int PHASE_BITS = 29;

    // ----------------------------------------
    // Codes
    // ----------------------------------------
    localparam logic [3:0] RATE_166HZ = 4'h0;
    localparam logic [3:0] RATE_400HZ = 4'h1;
    localparam logic [3:0] RATE_1KHZ = 4'h2;
    localparam logic [3:0] RATE_2KHZ = 4'h3;
    localparam logic [3:0] RATE_4KHZ = 4'h4;
    localparam logic [3:0] RATE_8KHZ = 4'h5;
    localparam logic [3:0] RATE_32KHZ = 4'h6;
    localparam logic [3:0] RATE_64KHZ = 4'h7;
    localparam logic [3:0] RATE_1HZ = 4'h8;

    localparam logic [2:0] WID_4M = 3'h0;
    localparam logic [2:0] WID_8M = 3'h1;
    localparam logic [2:0] WID_16M = 3'h2;
    localparam logic [2:0] WID_32M = 3'h3;
    localparam logic [2:0] WID_65M = 3'h4;
    localparam logic [2:0] WID_SYN = 3'h7;

    // ----------------------------------------
    // Timing, in delay units of the fine clock
    // ----------------------------------------
    localparam int UNIT_FREQ_KHZ = 262144;
    localparam int SLOT_FREQ_KHZ = 64;
    localparam int UNITS_PER_SLOT_DEF = UNIT_FREQ_KHZ / SLOT_FREQ_KHZ;
    localparam int WID_4M_UNITS = UNIT_FREQ_KHZ / 4096;
    localparam int WID_8M_UNITS = UNIT_FREQ_KHZ / 8192;
    localparam int WID_16M_UNITS = UNIT_FREQ_KHZ / 16384;
    localparam int WID_32M_UNITS = UNIT_FREQ_KHZ / 32768;
    localparam int WID_65M_UNITS = UNIT_FREQ_KHZ / 65536;

    // Frame periods in 64 kHz slots
    localparam int SLOTS_166HZ = 384;
    localparam int SLOTS_400HZ = 160;
    localparam int SLOTS_1KHZ = 64;
    localparam int SLOTS_2KHZ = 32;
    localparam int SLOTS_4KHZ = 16;
    localparam int SLOTS_8KHZ = 8;
    localparam int SLOTS_32KHZ = 2;
    localparam int SLOTS_64KHZ = 1;
    localparam int SLOTS_1HZ = 64000;

    localparam int HIGH_1HZ_MS = 4;
    localparam int HIGH_1HZ_SLOTS = HIGH_1HZ_MS * SLOT_FREQ_KHZ;
    localparam int SLOTS_PER_8K = SLOTS_8KHZ;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } fsp_bus_t;

    typedef enum logic [1:0] {
        FSP_WAIT,
        FSP_ARM,
        FSP_HIGH
    } fsp_state_t;

endpackage

/* verilog/fsp_frame_pulse_shaper.sv */
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module fsp_frame_pulse_shaper #(
    parameter int UNITS_PER_SLOT = fsp_pkg::UNITS_PER_SLOT_DEF
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire fsp_pkg::fsp_bus_t bus,
    input wire logic unit_tick,
    input wire logic syn_rise,
    input wire logic syn_fall,
    output logic [7:0] rdata,
    output logic fp_out
);
    import fsp_pkg::*;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] rate_ff;
    logic [7:0] shape_ff;
    logic [7:0] ofs_low_ff;
    logic [7:0] ofs_mid_ff;
    logic [OFS_HIGH_BITS-1:0] ofs_high_ff;
    logic [7:0] rdata_ff;
    logic [PHASE_BITS-1:0] ph_ff;
    logic [PHASE_BITS-1:0] cnt_ff;
    fsp_state_t st_ff;
    logic fp_out_ff;

    logic [3:0] rate_code;
    logic style;
    logic edge_fall;
    logic [2:0] width_code;
    logic pol;
    logic rate_ok;
    logic wid_ok;
    logic [PHASE_BITS-1:0] period;
    logic [PHASE_BITS-1:0] delay_total;
    logic [PHASE_BITS-1:0] high_len;
    logic [OFS_BITS-1:0] ofs_word;
    logic trig;
    logic sync_ev;
    logic syn_width;
    logic [7:0] status;

    assign rate_code = rate_ff[3:0];
    assign style = shape_ff[SHAPE_STYLE_BIT];
    assign edge_fall = shape_ff[SHAPE_EDGE_BIT];
    assign width_code = shape_ff[SHAPE_WIDTH_LSB +: 3];
    assign pol = shape_ff[SHAPE_POL_BIT];
    assign ofs_word = {ofs_high_ff, ofs_mid_ff, ofs_low_ff};

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rate_ff <= RATE_RST;
            shape_ff <= SHAPE_RST;
            ofs_low_ff <= OFS_RST;
            ofs_mid_ff <= OFS_RST;
            ofs_high_ff <= OFS_RST[OFS_HIGH_BITS-1:0];
        end else if (ce && bus.wr) begin
            // Reserved bits are not stored and read back as zero
            if (bus.addr == ADDR_RATE) begin
                rate_ff <= {4'h0, bus.wdata[3:0]};
            end else if (bus.addr == ADDR_SHAPE) begin
                shape_ff <= {bus.wdata[7:4], 2'h0, bus.wdata[1:0]};
            end else if (bus.addr == ADDR_OFS_LOW) begin
                ofs_low_ff <= bus.wdata;
            end else if (bus.addr == ADDR_OFS_MID) begin
                ofs_mid_ff <= bus.wdata;
            end else if (bus.addr == ADDR_OFS_HIGH) begin
                ofs_high_ff <= bus.wdata[OFS_HIGH_BITS-1:0];
            end
        end
    end

    assign status = {5'h00, rate_ok & wid_ok, st_ff == FSP_HIGH, st_ff == FSP_ARM};

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_ff <= 8'h00;
        end else if (ce) begin
            // Zero outside the answer cycle, so a stale byte is never taken twice
            if (!bus.rd) begin
                rdata_ff <= 8'h00;
            end else if (bus.addr == ADDR_RATE) begin
                rdata_ff <= rate_ff;
            end else if (bus.addr == ADDR_SHAPE) begin
                rdata_ff <= shape_ff;
            end else if (bus.addr == ADDR_OFS_LOW) begin
                rdata_ff <= ofs_low_ff;
            end else if (bus.addr == ADDR_OFS_MID) begin
                rdata_ff <= ofs_mid_ff;
            end else if (bus.addr == ADDR_OFS_HIGH) begin
                rdata_ff <= {2'h0, ofs_high_ff};
            end else if (bus.addr == ADDR_STATUS) begin
                rdata_ff <= status;
            end else begin
                rdata_ff <= 8'h00;
            end
        end
    end

    // ----------------------------------------
    // Rate and width decode
    // ----------------------------------------
    // Units per slot is a parameter so that simulation can shrink every frame
    function automatic logic [PHASE_BITS-1:0] slots_to_units(input int slots);
        slots_to_units = PHASE_BITS'(slots * UNITS_PER_SLOT);
    endfunction

    always_comb begin
        rate_ok = 1'b1;
        period = slots_to_units(SLOTS_8KHZ);
        case (rate_code)
            RATE_166HZ: period = slots_to_units(SLOTS_166HZ);
            RATE_400HZ: period = slots_to_units(SLOTS_400HZ);
            RATE_1KHZ: period = slots_to_units(SLOTS_1KHZ);
            RATE_2KHZ: period = slots_to_units(SLOTS_2KHZ);
            RATE_4KHZ: period = slots_to_units(SLOTS_4KHZ);
            RATE_8KHZ: period = slots_to_units(SLOTS_8KHZ);
            RATE_32KHZ: period = slots_to_units(SLOTS_32KHZ);
            RATE_64KHZ: period = slots_to_units(SLOTS_64KHZ);
            RATE_1HZ: period = slots_to_units(SLOTS_1HZ);
            default: rate_ok = 1'b0;
        endcase
    end

    always_comb begin
        wid_ok = 1'b1;
        high_len = PHASE_BITS'(WID_4M_UNITS);
        if (!style) begin
            // Clock style: half the period, or a fixed 4 ms at 1 Hz
            if (rate_code == RATE_1HZ) begin
                high_len = slots_to_units(HIGH_1HZ_SLOTS);
            end else begin
                high_len = period >> 1;
            end
        end else begin
            case (width_code)
                WID_4M: high_len = PHASE_BITS'(WID_4M_UNITS);
                WID_8M: high_len = PHASE_BITS'(WID_8M_UNITS);
                WID_16M: high_len = PHASE_BITS'(WID_16M_UNITS);
                WID_32M: high_len = PHASE_BITS'(WID_32M_UNITS);
                WID_65M: high_len = PHASE_BITS'(WID_65M_UNITS);
                WID_SYN: high_len = PHASE_BITS'(WID_4M_UNITS);
                default: wid_ok = 1'b0;
            endcase
        end
    end

    assign syn_width = style && (width_code == WID_SYN);
    // At 1 Hz the edge bit is ignored and the rising edge is always used
    assign sync_ev = (edge_fall && rate_code != RATE_1HZ) ? syn_fall : syn_rise;
    // Offset must stay below the frame period, otherwise no pulse is produced
    assign delay_total = PHASE_BITS'(ofs_word[15:0])
        + PHASE_BITS'(ofs_high_ff) * slots_to_units(SLOTS_PER_8K);
    assign trig = unit_tick && (ph_ff == delay_total);

    // ----------------------------------------
    // Frame phase counter
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ph_ff <= '0;
        end else if (ce) begin
            // Parking at zero on a reserved rate makes the next valid rate start a fresh frame
            if (!rate_ok) begin
                ph_ff <= '0;
            end else if (unit_tick) begin
                if (ph_ff >= period - 1'b1) begin
                    ph_ff <= '0;
                end else begin
                    ph_ff <= ph_ff + 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // Pulse sequencer
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_ff <= FSP_WAIT;
            cnt_ff <= '0;
        end else if (ce) begin
            // A config error mid-pulse drops to WAIT rather than finish a pulse of unknown length
            case (st_ff)
                FSP_WAIT: begin
                    cnt_ff <= '0;
                    if (trig && rate_ok && wid_ok) begin
                        st_ff <= FSP_ARM;
                    end
                end
                FSP_ARM: begin
                    cnt_ff <= '0;
                    if (!rate_ok || !wid_ok) begin
                        st_ff <= FSP_WAIT;
                    end else if (sync_ev) begin
                        st_ff <= FSP_HIGH;
                    end
                end
                FSP_HIGH: begin
                    if (!rate_ok || !wid_ok) begin
                        st_ff <= FSP_WAIT;
                    end else if (syn_width) begin
                        // One full synthesized cycle: ends at the next chosen edge
                        if (sync_ev) begin
                            st_ff <= FSP_WAIT;
                        end
                    end else if (unit_tick) begin
                        if (cnt_ff >= high_len - 1'b1) begin
                            st_ff <= FSP_WAIT;
                            cnt_ff <= '0;
                        end else begin
                            cnt_ff <= cnt_ff + 1'b1;
                        end
                    end
                end
                default: begin
                    st_ff <= FSP_WAIT;
                    cnt_ff <= '0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Output stage
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            fp_out_ff <= SHAPE_RST[SHAPE_POL_BIT];
        end else if (ce) begin
            fp_out_ff <= (st_ff == FSP_HIGH) ^ pol;
        end
    end

    assign rdata = rdata_ff;
    assign fp_out = fp_out_ff;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Reset pauses every check, but history functions can still look back into reset, as $stable(pol) in chk_polarity_idle does
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    chk_rate_wrap: assert property (
        (ce && rate_ok && unit_tick && ph_ff == period - 1'b1) |=> (ph_ff == '0)
    ) else $error("phase counter did not wrap at the frame period");

    chk_reserved_rate: assert property (
        (ce && !rate_ok) |=> (st_ff == FSP_WAIT && ph_ff == '0)
    ) else $error("reserved rate code did not idle the generator");

    // Ends are checked at the terminal count, since software may retune mid-pulse
    chk_clock_high: assert property (
        (ce && st_ff == FSP_HIGH && !style && rate_ok && rate_code != RATE_1HZ && unit_tick
            && cnt_ff == (period >> 1) - 1'b1) |=> (st_ff == FSP_WAIT)
    ) else $error("clock style high interval did not end at half period");

    chk_one_hz_high: assert property (
        (ce && st_ff == FSP_HIGH && !style && rate_code == RATE_1HZ && unit_tick
            && cnt_ff == PHASE_BITS'(HIGH_1HZ_SLOTS * UNITS_PER_SLOT) - 1'b1) |=> (st_ff == FSP_WAIT)
    ) else $error("1 Hz clock high interval did not end at its fixed length");

    chk_edge_align: assert property (
        (ce && st_ff == FSP_ARM && rate_ok && wid_ok) |=> ((st_ff == FSP_HIGH) ==
            (($past(edge_fall) && $past(rate_code) != RATE_1HZ) ? $past(syn_fall) : $past(syn_rise)))
    ) else $error("pulse did not start on the selected sync edge");

    chk_arm_hold: assert property (
        (ce && st_ff == FSP_ARM && rate_ok && wid_ok && !syn_rise && !syn_fall) |=> (st_ff == FSP_ARM)
    ) else $error("pulse started away from a sync edge");

    chk_width_units: assert property (
        (st_ff == FSP_HIGH && style && width_code <= WID_65M) |->
            (cnt_ff < PHASE_BITS'(WID_4M_UNITS))
    ) else $error("frame pulse ran past its width count");

    chk_width_end: assert property (
        (ce && st_ff == FSP_HIGH && style && width_code == WID_65M && unit_tick
            && cnt_ff == PHASE_BITS'(WID_65M_UNITS) - 1'b1) |=> (st_ff == FSP_WAIT)
    ) else $error("shortest fixed width pulse did not end on time");

    chk_reserved_width: assert property (
        (ce && style && (width_code == 3'h5 || width_code == 3'h6)) |=> (st_ff == FSP_WAIT)
    ) else $error("reserved width code did not idle the generator");

    chk_syn_width_end: assert property (
        (ce && st_ff == FSP_HIGH && syn_width && sync_ev) |=> (st_ff == FSP_WAIT)
    ) else $error("one cycle width did not end at the next sync edge");

    chk_polarity_idle: assert property (
        (ce && st_ff == FSP_WAIT && $stable(pol)) [*2] |-> (fp_out_ff == pol)
    ) else $error("idle output level does not follow polarity");

    chk_polarity_active: assert property (
        (ce && st_ff == FSP_HIGH) |=> (fp_out_ff != $past(pol))
    ) else $error("active output level does not oppose polarity");

    chk_offset_bytes: assert property (
        (ce && bus.wr && bus.addr == ADDR_OFS_MID) |=> (ofs_word[15:8] == $past(bus.wdata))
    ) else $error("mid offset byte not stored");

    chk_trigger_offset: assert property (
        (ce && st_ff == FSP_WAIT && rate_ok && wid_ok && unit_tick && ph_ff == delay_total)
            |=> (st_ff == FSP_ARM)
    ) else $error("pulse not armed at the programmed offset");

    chk_coarse_offset: assert property (
        (ce && st_ff == FSP_WAIT && rate_ok && wid_ok) ##1 (st_ff == FSP_ARM) |->
            ($past(ph_ff) == PHASE_BITS'({$past(ofs_mid_ff), $past(ofs_low_ff)})
            + PHASE_BITS'($past(ofs_high_ff)) * PHASE_BITS'(SLOTS_PER_8K * UNITS_PER_SLOT))
    ) else $error("pulse not armed at the fine plus coarse offset");

    chk_read_once: assert property (
        (ce && !bus.rd) |=> (rdata_ff == 8'h00)
    ) else $error("read data outside the read answer cycle");

    chk_read_answer: assert property (
        (ce && bus.rd && bus.addr == ADDR_OFS_LOW)
            |=> (rdata_ff == $past(ofs_low_ff))
    ) else $error("low offset byte not returned in the answer cycle");

    chk_ce_freeze: assert property (
        !ce |=> ($stable(ph_ff) && $stable(st_ff) && $stable(rdata_ff)
            && $stable(fp_out_ff) && $stable(shape_ff))
    ) else $error("state moved while the clock enable was low");

    cov_frame_pulse: cover property (ce && style && st_ff == FSP_HIGH ##1 st_ff == FSP_WAIT);
    cov_clock_style: cover property (ce && !style && st_ff == FSP_HIGH);
    cov_falling_edge: cover property (ce && edge_fall && st_ff == FSP_ARM && syn_fall);
    cov_syn_width: cover property (ce && syn_width && st_ff == FSP_HIGH && sync_ev);
    cov_one_hz: cover property (ce && !style && rate_code == RATE_1HZ && st_ff == FSP_HIGH);

endmodule
`default_nettype wire

/* verification/frame_pulse_shaper_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module frame_pulse_shaper_tb;
    import fsp_pkg::*;

    // ----------------------------------------
    // Clock, stimulus and design
    // ----------------------------------------
    // Small slot keeps every frame but the 1 Hz one short; slot-based figures below scale with it, fixed pulse widths do not
    localparam int U = 8;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic ce = 1'b1;
    fsp_bus_t bus = '0;
    logic [7:0] rdata;
    logic fp_out;
    logic pol = 1'b1;
    logic [31:0] cyc = 32'h0;
    logic unit_tick;
    logic syn_rise;
    logic syn_fall;
    int n_errors = 0;
    int samples_checked = 0;

    always #20 mclk = ~mclk;
    always @(posedge mclk) cyc <= sys_rst ? 32'h0 : cyc + {31'h0, ce};
    // Unit every 2 cycles, sync clock every 4; falling strobe lags rising by 2
    assign unit_tick = cyc[0];
    assign syn_rise = (cyc[1:0] == 2'h1);
    assign syn_fall = (cyc[1:0] == 2'h3);

    fsp_frame_pulse_shaper #(.UNITS_PER_SLOT(U)) u_dut (.mclk(mclk), .sys_rst(sys_rst), .ce(ce), .bus(bus),
        .unit_tick(unit_tick), .syn_rise(syn_rise), .syn_fall(syn_fall), .rdata(rdata), .fp_out(fp_out));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // Unit counting starts on a sync strobe, so one cycle of slack is allowed
    task automatic near(input string what, input int exp, input int got);
        check(what, exp, (got >= exp - 1 && got <= exp + 1) ? exp : got);
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        @(negedge mclk);
        check(what, exp, rdata);
    endtask

    task automatic do_reset;
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        pol = 1'b1;
    endtask

    // Waits for the level lvl (output xor polarity) to start anew
    task automatic wait_act(input logic lvl, output int t);
        int n;
        n = 0;
        while (((fp_out ^ pol) === lvl) && n < 20000) begin
            @(negedge mclk);
            n++;
        end
        while (((fp_out ^ pol) !== lvl) && n < 20000) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 20000) begin
            n_errors++;
            $display("MISMATCH fp_out edge expected toggle seen stuck");
        end
        t = int'(cyc);
    endtask

    // First pulse after a change is discarded, it may be cut short
    task automatic measure(output int t0, output int hi, output int per);
        int t1;
        int t2;
        wait_act(1'b1, t1);
        wait_act(1'b1, t0);
        wait_act(1'b0, t1);
        wait_act(1'b1, t2);
        hi = t1 - t0;
        per = t2 - t0;
    endtask

    task automatic idle_chk(input string what, input int n);
        int hits;
        hits = 0;
        repeat (8) @(negedge mclk);
        repeat (n) begin
            @(negedge mclk);
            if ((fp_out ^ pol) === 1'b1) hits++;
        end
        check(what, 0, hits);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        @(negedge mclk);
        check("fp_out after reset", 1, fp_out);
        rd_chk(ADDR_RATE, RATE_RST, "rate reset");
        rd_chk(ADDR_SHAPE, SHAPE_RST, "shape reset");
        rd_chk(ADDR_OFS_LOW, OFS_RST, "offset low reset");
        rd_chk(ADDR_OFS_MID, OFS_RST, "offset mid reset");
        wr_reg(ADDR_RATE, 8'hF7);
        rd_chk(ADDR_RATE, 8'h07, "rate reserved bits");
        wr_reg(ADDR_SHAPE, 8'hFF);
        rd_chk(ADDR_SHAPE, 8'hF3, "shape reserved bits");
        wr_reg(ADDR_OFS_LOW, 8'hA5);
        wr_reg(ADDR_OFS_MID, 8'h5A);
        rd_chk(ADDR_OFS_LOW, 8'hA5, "offset low");
        rd_chk(ADDR_OFS_MID, 8'h5A, "offset mid");
        wr_reg(8'h7F, 8'hFF);
        rd_chk(8'h7F, 8'h00, "unmapped read");
        // Read data must hold while the clock enable is low
        @(posedge mclk);
        bus <= '{addr: ADDR_OFS_LOW, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        ce <= 1'b0;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        check("rdata frozen", 8'hA5, rdata);
        @(posedge mclk);
        ce <= 1'b1;
    endtask

    task automatic t_rates;
        int slots[8] = '{SLOTS_166HZ, SLOTS_400HZ, SLOTS_1KHZ, SLOTS_2KHZ,
                         SLOTS_4KHZ, SLOTS_8KHZ, SLOTS_32KHZ, SLOTS_64KHZ};
        int t0;
        int hi;
        int per;
        pol = 1'b0;
        wr_reg(ADDR_SHAPE, 8'h00);
        for (int c = 0; c < 8; c++) begin
            wr_reg(ADDR_RATE, 8'(c));
            measure(t0, hi, per);
            check("clock period", slots[c] * U * 2, per);
            near("clock high", slots[c] * U, hi);
        end
        wr_reg(ADDR_RATE, 8'h09);
        idle_chk("reserved rate idle", 600);
    endtask

    task automatic t_width;
        int wu[5] = '{WID_4M_UNITS, WID_8M_UNITS, WID_16M_UNITS, WID_32M_UNITS, WID_65M_UNITS};
        int t0;
        int hi;
        int per;
        pol = 1'b1;
        wr_reg(ADDR_RATE, {4'h0, RATE_4KHZ});
        // Unit tick is taken as an E1 multiple, so codes 000 to 100 are allowed
        for (int w = 0; w < 5; w++) begin
            wr_reg(ADDR_SHAPE, {1'b1, 3'(w), 4'h1});
            measure(t0, hi, per);
            check("pulse period", SLOTS_4KHZ * U * 2, per);
            near("pulse width", wu[w] * 2, hi);
        end
        wr_reg(ADDR_SHAPE, {1'b1, WID_SYN, 4'h1});
        measure(t0, hi, per);
        near("sync width", 4, hi);
        wr_reg(ADDR_SHAPE, {1'b1, 3'h5, 4'h1});
        idle_chk("reserved width idle", 600);
    endtask

    task automatic t_edge;
        int t0;
        int t1;
        int hi;
        int per;
        pol = 1'b0;
        wr_reg(ADDR_RATE, {4'h0, RATE_64KHZ});
        wr_reg(ADDR_SHAPE, {1'b0, WID_65M, 4'h1});
        measure(t0, hi, per);
        wr_reg(ADDR_SHAPE, {1'b0, WID_65M, 4'h3});
        measure(t1, hi, per);
        check("edge shift", 2, (t1 - t0 + 4000) % 4);
    endtask

    task automatic t_offset;
        int t0;
        int t1;
        int hi;
        int per;
        pol = 1'b0;
        wr_reg(ADDR_RATE, {4'h0, RATE_400HZ});
        wr_reg(ADDR_SHAPE, {1'b0, WID_SYN, 4'h1});
        measure(t0, hi, per);
        wr_reg(ADDR_OFS_LOW, 8'h04);
        wr_reg(ADDR_OFS_MID, 8'h01);
        wr_reg(ADDR_OFS_HIGH, 8'h01);
        measure(t1, hi, per);
        check("offset period", SLOTS_400HZ * U * 2, per);
        // 4 + 256 units, plus one 8 kHz period of 8*U units, two cycles per unit
        check("offset shift", (4 + 256 + SLOTS_PER_8K * U) * 2, (t1 - t0) % per);
    endtask

    // A reserved code parks the phase at zero, so the 1 Hz frame starts without a long wait
    task automatic t_one_hz;
        int t0;
        int t1;
        pol = 1'b0;
        wr_reg(ADDR_RATE, 8'h09);
        wr_reg(ADDR_SHAPE, 8'h02);
        wr_reg(ADDR_RATE, {4'h0, RATE_1HZ});
        wait_act(1'b1, t0);
        wait_act(1'b0, t1);
        check("1 Hz high", HIGH_1HZ_SLOTS * U * 2, t1 - t0);
        // Rising strobes put the first active sample at 3 mod 4, falling ones at 1
        check("1 Hz edge", 3, t0 % 4);
    endtask

    // ----------------------------------------
    // Run control
    // ----------------------------------------
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        t_regs;
        do_reset;
        t_rates;
        t_width;
        t_edge;
        t_offset;
        t_one_hz;
        tally_and_finish;
    end

    // Tests need roughly 60k cycles; 90k means a hang
    initial begin
        #3600000;
        n_errors++;
        $display("MISMATCH watchdog expected done seen running");
        tally_and_finish;
    end
endmodule
`default_nettype wire
